// *** core/mfo_crc12.sv ***
// Purpose: Bit-serial twelfth-order check code register
// Assumes: Clear and shift are single-cycle strobes
// Notes: Clear wins over shift
`timescale 1ns/10ps
`include "mfo_params.svh"

module mfo_crc12 (
    input wire logic i_sys_clk,
    input wire logic i_nrst,
    input wire logic i_clr,
    input wire logic i_shift,
    input wire logic i_bit,
    output logic [11:0] o_crc
);
    localparam logic [11:0] POLY = `MFO_CRC_POLY;
    logic [11:0] crc_r;
    logic [11:0] crc_nxt;
    logic fb;

    assign fb = i_bit ^ crc_r[11];
    assign o_crc = crc_r;

    // Each cell takes its lower neighbour, tapped by the feedback per polynomial
    for (genvar g = 0; g < 12; g++) begin : g_cell
        always_comb begin
            if (i_clr) begin
                crc_nxt[g] = 1'b0;
            end else if (i_shift) begin
                crc_nxt[g] = (g == 0 ? 1'b0 : crc_r[(g == 0) ? 0 : g - 1]) ^ (fb & POLY[g]);
            end else begin
                crc_nxt[g] = crc_r[g];
            end
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            crc_r <= `MFO_CRC_RST;
        end else begin
            crc_r <= crc_nxt;
        end
    end
endmodule : mfo_crc12

// *** core/mfo_engine.sv ***
// Purpose: Overhead bits, check code and operations channel of the network termination
// Assumes: Framer gives multiframe start and one strobe per line bit with its kind
// Notes: Registers over Avalon-MM; tx bit appears one cycle after its strobe
//
// Overview of operation
// - Check code uses generator with terms 12, 11, 3, 2, 1, 0.
// - Check register cleared to zero at every multiframe start.
// - Check register frozen on frame word and first, second, third, fifth, sixth overhead bits.
// - Check covers user data bits and fourth overhead bits only.
// - Final register latched; check bit one from cell 12, two from cell 11.
// - Twelve check bits go in fifth/sixth overhead bits of frames three to eight.
// - Receiver recomputes the check and flags mismatching multiframes.
// - A changed fourth-overhead status is sent in at least three multiframes.
// - Block error return bit: ONE clean, ZERO errored, sent next multiframe.
// - Activation indicator in frame one driven ONE when ready.
// - Power status and test mode bits sent ONE when unused.
// - Cold start only bit sent ZERO in operating state.
// - Frame seven interface activity bit ONE when unused.
// - Frame eight network indicator bit always ONE.
// - Unassigned fourth, fifth, sixth overhead bits sent as ONE.
// - Operations frame: 3-bit address, flag, 8-bit info; two per multiframe.
// - Flag ONE means message, ZERO means numerical data.
// - Act only after three identical consecutive addressed recognised frames.
// - Answer every frame in the next returning frame, within processing delay.
// - Unrecognised message or data: unable-to-comply from third identical receipt.
// - Foreign address answered with hold-state message under own address.
// - Actions latch and stay until a release message arrives.
// - Unable-to-comply always carries own address 000.
//
// Our own choices: register access over Avalon-MM and the placing of the registers.
`timescale 1ns/10ps
`include "mfo_params.svh"

module mfo_engine #(
    parameter int P_PROC_CYCLES = `MFO_EOC_PROC_CYC,
    parameter int P_ERR_CNT_W = 16
) (
    input wire logic i_sys_clk,
    input wire logic i_nrst,
    input wire logic i_mf_start,
    input wire logic i_bit_stb,
    input wire mfo_pkg::mfo_bit_kind_t i_bit_kind,
    input wire logic [2:0] i_frame_idx,
    input wire logic i_rx_bit,
    input wire logic i_tx_bit,
    input wire logic [3:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    input wire logic [3:0] i_avs_byteenable,
    output logic [31:0] o_avs_readdata,
    output logic o_avs_waitrequest,
    output logic o_tx_bit,
    output logic o_tx_stb,
    output logic o_mf_errored,
    output logic o_loop_2bd,
    output logic o_loop_b1,
    output logic o_loop_b2,
    output logic o_corrupt_crc,
    output logic o_notify_crc
);
    if (P_PROC_CYCLES < 1) begin : g_chk_proc
        $error("P_PROC_CYCLES must be at least 1");
    end
    if (P_ERR_CNT_W < 1 || P_ERR_CNT_W > 32) begin : g_chk_cnt
        $error("P_ERR_CNT_W must be 1 to 32");
    end

    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_nrst);

    // Position decode from framer
    logic is_eoc;
    logic cov;
    logic eoc_done;
    logic crc_slot;
    assign is_eoc = i_bit_stb && (i_bit_kind == mfo_pkg::MFO_K_M1
        || i_bit_kind == mfo_pkg::MFO_K_M2 || i_bit_kind == mfo_pkg::MFO_K_M3);
    assign cov = i_bit_kind == mfo_pkg::MFO_K_DATA || i_bit_kind == mfo_pkg::MFO_K_M4;
    assign eoc_done = i_bit_stb && i_bit_kind == mfo_pkg::MFO_K_M3
        && i_frame_idx[1:0] == 2'h3;
    assign crc_slot = i_frame_idx >= 3'h2;

    // Transmit side
    logic [4:0] ctrl_r, ctrl_nxt;
    logic [4:0] act_r, act_nxt;
    logic [7:0] m4_cur_r, m4_cur_nxt;
    logic [7:0] m4_want;
    logic [1:0] hold_cnt_r, hold_cnt_nxt;
    logic [11:0] tx_field_r, tx_field_nxt;
    logic [11:0] eoc_tx_r, eoc_tx_nxt;
    logic tx_bit_r, tx_bit_nxt;
    logic tx_stb_r;
    mfo_pkg::mfo_bit_kind_t tx_kind_r;
    logic [2:0] tx_idx_r;
    logic block_error_return_bit_r, block_error_return_bit_nxt;
    logic tx_val;
    logic [11:0] tx_crc;

    // Frame order: bit i is the fourth overhead bit of frame i+1
    assign m4_want = {1'b1, ctrl_r[`MFO_CTRL_SAI], 1'b1, 1'b0,
        ctrl_r[`MFO_CTRL_NTM], ctrl_r[`MFO_CTRL_PS2], ctrl_r[`MFO_CTRL_PS1],
        ctrl_r[`MFO_CTRL_ACT]};

    always_comb begin
        tx_val = i_tx_bit;
        case (i_bit_kind)
            mfo_pkg::MFO_K_DATA, mfo_pkg::MFO_K_FW: tx_val = i_tx_bit;
            mfo_pkg::MFO_K_M1, mfo_pkg::MFO_K_M2,
            mfo_pkg::MFO_K_M3: tx_val = eoc_tx_r[11];
            mfo_pkg::MFO_K_M4: tx_val = m4_cur_r[i_frame_idx];
            mfo_pkg::MFO_K_M5: tx_val = crc_slot ? tx_field_r[11] : 1'b1;
            mfo_pkg::MFO_K_M6: begin
                if (crc_slot) begin
                    tx_val = tx_field_r[10];
                end else if (i_frame_idx == 3'h1) begin
                    tx_val = block_error_return_bit_r;
                end else begin
                    tx_val = 1'b1;
                end
            end
            default: tx_val = 1'b1;
        endcase
    end

    mfo_crc12 u_tx_crc (
        .i_sys_clk(i_sys_clk),
        .i_nrst(i_nrst),
        .i_clr(i_mf_start),
        .i_shift(i_bit_stb && cov && !i_mf_start),
        .i_bit(tx_val),
        .o_crc(tx_crc)
    );

    always_comb begin
        m4_cur_nxt = m4_cur_r;
        hold_cnt_nxt = hold_cnt_r;
        tx_field_nxt = tx_field_r;
        tx_bit_nxt = i_bit_stb ? tx_val : tx_bit_r;
        if (i_mf_start) begin
            // Corrupting on request lets the network test its error counting
            tx_field_nxt = tx_crc ^ {12{act_r[`MFO_ACT_CORRUPT]}};
            if (m4_want != m4_cur_r && hold_cnt_r == `MFO_M4_REPEAT) begin
                m4_cur_nxt = m4_want;
                hold_cnt_nxt = 2'h1;
            end else if (hold_cnt_r != `MFO_M4_REPEAT) begin
                hold_cnt_nxt = hold_cnt_r + 2'h1;
            end
        end else if (i_bit_stb && i_bit_kind == mfo_pkg::MFO_K_M6 && crc_slot) begin
            tx_field_nxt = {tx_field_r[9:0], 2'h0};
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            m4_cur_r <= `MFO_M4_RST;
            hold_cnt_r <= `MFO_M4_REPEAT;
            tx_field_r <= `MFO_CRC_RST;
            tx_bit_r <= 1'b1;
            tx_stb_r <= 1'b0;
            tx_kind_r <= mfo_pkg::MFO_K_DATA;
            tx_idx_r <= 3'h0;
        end else begin
            m4_cur_r <= m4_cur_nxt;
            hold_cnt_r <= hold_cnt_nxt;
            tx_field_r <= tx_field_nxt;
            tx_bit_r <= tx_bit_nxt;
            tx_stb_r <= i_bit_stb;
            tx_kind_r <= i_bit_kind;
            tx_idx_r <= i_frame_idx;
        end
    end

    // Receive check
    logic [11:0] rx_crc;
    logic [11:0] rx_field_r, rx_field_nxt;
    logic [11:0] rx_prev_r, rx_prev_nxt;
    logic [1:0] mf_seen_r, mf_seen_nxt;
    logic mf_err_r, mf_err_nxt;
    logic [P_ERR_CNT_W-1:0] err_cnt_r, err_cnt_nxt;
    logic err_clr;

    mfo_crc12 u_rx_crc (
        .i_sys_clk(i_sys_clk),
        .i_nrst(i_nrst),
        .i_clr(i_mf_start),
        .i_shift(i_bit_stb && cov && !i_mf_start),
        .i_bit(i_rx_bit),
        .o_crc(rx_crc)
    );

    always_comb begin
        rx_field_nxt = rx_field_r;
        rx_prev_nxt = rx_prev_r;
        mf_seen_nxt = mf_seen_r;
        mf_err_nxt = 1'b0;
        block_error_return_bit_nxt = block_error_return_bit_r;
        err_cnt_nxt = err_clr ? '0 : err_cnt_r;
        if (i_mf_start) begin
            rx_prev_nxt = rx_crc;
            // Field in hand pairs with the check computed one multiframe earlier
            if (mf_seen_r == 2'h2) begin
                mf_err_nxt = rx_field_r != rx_prev_r;
                block_error_return_bit_nxt = rx_field_r == rx_prev_r;
                if (rx_field_r != rx_prev_r && err_cnt_nxt != '1) begin
                    err_cnt_nxt = err_cnt_nxt + 1'b1;
                end
            end else begin
                mf_seen_nxt = mf_seen_r + 2'h1;
            end
        end else if (i_bit_stb && crc_slot && (i_bit_kind == mfo_pkg::MFO_K_M5
            || i_bit_kind == mfo_pkg::MFO_K_M6)) begin
            rx_field_nxt = {rx_field_r[10:0], i_rx_bit};
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            rx_field_r <= `MFO_CRC_RST;
            rx_prev_r <= `MFO_CRC_RST;
            mf_seen_r <= 2'h0;
            mf_err_r <= 1'b0;
            block_error_return_bit_r <= 1'b1;
            err_cnt_r <= '0;
        end else begin
            rx_field_r <= rx_field_nxt;
            rx_prev_r <= rx_prev_nxt;
            mf_seen_r <= mf_seen_nxt;
            mf_err_r <= mf_err_nxt;
            block_error_return_bit_r <= block_error_return_bit_nxt;
            err_cnt_r <= err_cnt_nxt;
        end
    end

    // Operations channel
    logic [11:0] eoc_rx_r, eoc_rx_nxt;
    logic [11:0] last_rx_r, last_rx_nxt;
    logic [1:0] match_r, match_nxt;
    logic [11:0] frm;
    logic addr_ok;
    logic recog;
    logic pend_r, pend_nxt;
    logic [31:0] lat_r, lat_nxt;

    assign frm = {eoc_rx_r[10:0], i_rx_bit};
    assign addr_ok = frm[11:9] == `MFO_ADDR_OWN || frm[11:9] == `MFO_ADDR_BCAST;

    always_comb begin
        // Numerical data is never recognised: no data transfer support
        recog = 1'b0;
        if (frm[8]) begin
            case (frm[7:0])
                `MFO_MSG_LOOP_2BD, `MFO_MSG_LOOP_B1, `MFO_MSG_LOOP_B2,
                `MFO_MSG_CORRUPT, `MFO_MSG_NOTIFY, `MFO_MSG_RTN,
                `MFO_MSG_HOLD: recog = 1'b1;
                default: recog = 1'b0;
            endcase
        end
    end

    always_comb begin
        eoc_rx_nxt = is_eoc ? frm : eoc_rx_r;
        eoc_tx_nxt = is_eoc ? {eoc_tx_r[10:0], 1'b1} : eoc_tx_r;
        last_rx_nxt = last_rx_r;
        match_nxt = match_r;
        act_nxt = act_r;
        pend_nxt = pend_r && !(i_bit_stb && i_bit_kind == mfo_pkg::MFO_K_M1);
        lat_nxt = pend_nxt ? lat_r + 32'h1 : 32'h0;
        if (eoc_done) begin
            last_rx_nxt = frm;
            pend_nxt = 1'b1;
            lat_nxt = 32'h0;
            if (!addr_ok) begin
                match_nxt = 2'h0;
                eoc_tx_nxt = {`MFO_ADDR_OWN, 1'b1, `MFO_MSG_HOLD};
            end else begin
                // Network repeats until three matching echoes, so counting holds
                match_nxt = (frm == last_rx_r && match_r != 2'h0) ?
                    ((match_r == 2'h3) ? 2'h3 : match_r + 2'h1) : 2'h1;
                eoc_tx_nxt = frm;
                if (match_nxt == 2'h3 && !recog) begin
                    eoc_tx_nxt = {`MFO_ADDR_OWN, 1'b1, `MFO_MSG_UTC};
                end
                if (match_nxt == 2'h3 && recog) begin
                    case (frm[7:0])
                        `MFO_MSG_LOOP_2BD: act_nxt[`MFO_ACT_2BD] = 1'b1;
                        `MFO_MSG_LOOP_B1: act_nxt[`MFO_ACT_B1] = 1'b1;
                        `MFO_MSG_LOOP_B2: act_nxt[`MFO_ACT_B2] = 1'b1;
                        `MFO_MSG_CORRUPT: act_nxt[`MFO_ACT_CORRUPT] = 1'b1;
                        `MFO_MSG_NOTIFY: act_nxt[`MFO_ACT_NOTIFY] = 1'b1;
                        `MFO_MSG_RTN: act_nxt = 5'h00;
                        default: act_nxt = act_r;
                    endcase
                end
            end
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            eoc_rx_r <= 12'h000;
            eoc_tx_r <= `MFO_EOC_IDLE;
            last_rx_r <= 12'h000;
            match_r <= 2'h0;
            act_r <= 5'h00;
            pend_r <= 1'b0;
            lat_r <= 32'h0;
        end else begin
            eoc_rx_r <= eoc_rx_nxt;
            eoc_tx_r <= eoc_tx_nxt;
            last_rx_r <= last_rx_nxt;
            match_r <= match_nxt;
            act_r <= act_nxt;
            pend_r <= pend_nxt;
            lat_r <= lat_nxt;
        end
    end

    // Avalon-MM slave: one wait cycle, then the answer at the sampling edge
    mfo_pkg::mfo_bus_st_t bus_r, bus_nxt;
    logic [31:0] rdata_r, rdata_nxt;
    logic req;
    logic take;

    assign req = i_avs_read || i_avs_write;
    assign take = req && bus_r == mfo_pkg::MFO_BUS_ACK;
    assign err_clr = take && i_avs_write && i_avs_address == `MFO_OFS_ERRCNT;

    always_comb begin
        bus_nxt = bus_r;
        rdata_nxt = rdata_r;
        ctrl_nxt = ctrl_r;
        case (bus_r)
            mfo_pkg::MFO_BUS_IDLE: begin
                if (req) begin
                    bus_nxt = mfo_pkg::MFO_BUS_ACK;
                    case (i_avs_address)
                        `MFO_OFS_CTRL: rdata_nxt = {27'h0, ctrl_r};
                        `MFO_OFS_STAT: rdata_nxt = {25'h0, mf_seen_r == 2'h2, block_error_return_bit_r, act_r};
                        `MFO_OFS_EOC: rdata_nxt = {4'h0, eoc_tx_r, 4'h0, last_rx_r};
                        `MFO_OFS_ERRCNT: rdata_nxt = 32'(err_cnt_r);
                        default: rdata_nxt = 32'h0;
                    endcase
                end
            end
            mfo_pkg::MFO_BUS_ACK: begin
                bus_nxt = mfo_pkg::MFO_BUS_IDLE;
                if (take && i_avs_write && i_avs_address == `MFO_OFS_CTRL
                    && i_avs_byteenable[0]) begin
                    ctrl_nxt = i_avs_writedata[4:0];
                end
            end
            default: bus_nxt = mfo_pkg::MFO_BUS_IDLE;
        endcase
    end

    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            bus_r <= mfo_pkg::MFO_BUS_IDLE;
            rdata_r <= 32'h0;
            ctrl_r <= `MFO_CTRL_RST;
        end else begin
            bus_r <= bus_nxt;
            rdata_r <= rdata_nxt;
            ctrl_r <= ctrl_nxt;
        end
    end

    assign o_avs_readdata = rdata_r;
    assign o_avs_waitrequest = bus_r[0];
    assign o_tx_bit = tx_bit_r;
    assign o_tx_stb = tx_stb_r;
    assign o_mf_errored = mf_err_r;
    assign o_loop_2bd = act_r[`MFO_ACT_2BD];
    assign o_loop_b1 = act_r[`MFO_ACT_B1];
    assign o_loop_b2 = act_r[`MFO_ACT_B2];
    assign o_corrupt_crc = act_r[`MFO_ACT_CORRUPT];
    assign o_notify_crc = act_r[`MFO_ACT_NOTIFY];

    a_crc_clear: assert property (i_mf_start |=> tx_crc == 12'h000)
        else $error("check register not cleared at multiframe start");
    a_crc_freeze: assert property (i_bit_stb && !cov && !i_mf_start |=> $stable(tx_crc))
        else $error("check register moved on uncovered bit");
    a_crc_latch: assert property (i_mf_start && !act_r[`MFO_ACT_CORRUPT]
        |=> tx_field_r == $past(tx_crc))
        else $error("check code not latched");
    a_crc_send: assert property (o_tx_stb && tx_kind_r == mfo_pkg::MFO_K_M5
        && tx_idx_r >= 3'h2 |-> o_tx_bit == $past(tx_field_r[11]))
        else $error("check bit sent out of order");
    a_block_error_return_bit_value: assert property (i_mf_start && mf_seen_r == 2'h2
        |=> block_error_return_bit_r == ($past(rx_field_r) == $past(rx_prev_r)) && o_mf_errored != block_error_return_bit_r)
        else $error("block error return bit wrong");
    a_block_error_return_bit_sent: assert property (o_tx_stb && tx_kind_r == mfo_pkg::MFO_K_M6
        && tx_idx_r == 3'h1 |-> o_tx_bit == block_error_return_bit_r)
        else $error("block error return bit not sent");
    a_reserved_one: assert property (o_tx_stb && tx_idx_r == 3'h0
        && (tx_kind_r == mfo_pkg::MFO_K_M5 || tx_kind_r == mfo_pkg::MFO_K_M6) |-> o_tx_bit)
        else $error("reserved bit not ONE");
    a_cso_zero: assert property (o_tx_stb && tx_kind_r == mfo_pkg::MFO_K_M4
        && tx_idx_r == 3'h4 |-> !o_tx_bit)
        else $error("cold start only bit not ZERO");
    a_nib_one: assert property (o_tx_stb && tx_kind_r == mfo_pkg::MFO_K_M4
        && tx_idx_r == 3'h7 |-> o_tx_bit)
        else $error("network indicator bit not ONE");
    a_m4_repeat: assert property ($changed(m4_cur_r) |-> $past(hold_cnt_r) == 2'h3)
        else $error("status bits changed too soon");
    a_hold_reply: assert property (eoc_done && !addr_ok
        |=> eoc_tx_r == {3'h0, 1'b1, 8'h00})
        else $error("foreign address not answered with hold");
    a_utc_reply: assert property (eoc_done && addr_ok && frm == last_rx_r
        && match_r >= 2'h2 && !recog |=> eoc_tx_r == 12'h1aa)
        else $error("unable to comply not returned");
    a_action_three: assert property ($rose(o_loop_2bd)
        |-> $past(match_r) >= 2'h2 && $past(eoc_done))
        else $error("action started without three matches");
    a_action_latch: assert property (o_loop_2bd && !(eoc_done && frm[7:0] == 8'hff)
        |=> o_loop_2bd)
        else $error("latched action dropped");
    a_reply_delay: assert property (lat_r < P_PROC_CYCLES)
        else $error("reply not sent within processing delay");

endmodule : mfo_engine

// *** core/mfo_params.svh ***
// Purpose: Constants for the multiframe overhead and operations channel engine
// Assumes: 10 MHz system clock
// Notes: Included by bare name; definitions only
`ifndef MFO_PARAMS_SVH
`define MFO_PARAMS_SVH

`define MFO_CLK_MHZ 10
`define MFO_EOC_PROC_US 2250
`define MFO_EOC_PROC_CYC (`MFO_EOC_PROC_US * `MFO_CLK_MHZ)

`define MFO_CRC_POLY 12'h80f
`define MFO_CRC_RST 12'h000
`define MFO_M4_REPEAT 2'h3
`define MFO_M4_RST 8'hee

`define MFO_ADDR_OWN 3'h0
`define MFO_ADDR_BCAST 3'h7
`define MFO_MSG_LOOP_2BD 8'h50
`define MFO_MSG_LOOP_B1 8'h51
`define MFO_MSG_LOOP_B2 8'h52
`define MFO_MSG_CORRUPT 8'h53
`define MFO_MSG_NOTIFY 8'h54
`define MFO_MSG_RTN 8'hff
`define MFO_MSG_HOLD 8'h00
`define MFO_MSG_UTC 8'haa
`define MFO_EOC_IDLE 12'h100

`define MFO_OFS_CTRL 4'h0
`define MFO_OFS_STAT 4'h4
`define MFO_OFS_EOC 4'h8
`define MFO_OFS_ERRCNT 4'hc

`define MFO_CTRL_RST 5'h1e
`define MFO_CTRL_ACT 0
`define MFO_CTRL_PS1 1
`define MFO_CTRL_PS2 2
`define MFO_CTRL_NTM 3
`define MFO_CTRL_SAI 4

`define MFO_ACT_2BD 0
`define MFO_ACT_B1 1
`define MFO_ACT_B2 2
`define MFO_ACT_CORRUPT 3
`define MFO_ACT_NOTIFY 4
`define MFO_STAT_BLOCK_ERROR_RETURN_BIT 5
`define MFO_STAT_VALID 6
`define MFO_EOC_TX_LSB 16

`endif

// *** core/mfo_pkg.sv ***
// Purpose: Types shared by the overhead engine files
// Assumes: Nothing
// Notes: Constants live in mfo_params.svh
package mfo_pkg;

    typedef enum logic [2:0] {
        MFO_K_DATA = 3'h0,
        MFO_K_FW = 3'h1,
        MFO_K_M1 = 3'h2,
        MFO_K_M2 = 3'h3,
        MFO_K_M3 = 3'h4,
        MFO_K_M4 = 3'h5,
        MFO_K_M5 = 3'h6,
        MFO_K_M6 = 3'h7
    } mfo_bit_kind_t;

    typedef enum logic [1:0] {
        MFO_BUS_IDLE = 2'b01,
        MFO_BUS_ACK = 2'b10
    } mfo_bus_st_t;

endpackage : mfo_pkg

// *** testbench/mfo_engine_tb.sv ***
// Purpose: Self-checking bench for the overhead engine
// Assumes: Line side model drives the framer strobes
// Notes: Row table walks the operations channel messages
`timescale 1ns/10ps
module mfo_engine_tb;
    logic i_sys_clk = 0;
    logic i_nrst = 0;
    logic rd = 0;
    logic wr = 0;
    logic bad = 0;
    logic [3:0] adr = 4'h0;
    logic [31:0] wd = 32'h0;
    logic [31:0] q, rdat;
    logic [11:0] ew = 12'h100;
    logic ms, st, rx, td, tb, ts, er, wq, ok;
    logic [2:0] fi;
    logic [4:0] ac;
    logic [7:0] m4;
    logic [3:0] rs;
    logic [23:0] eo;
    logic [15:0] mc;
    mfo_pkg::mfo_bit_kind_t kd;
    int n_mismatch = 0;
    int samples_checked = 0;
    int ne = 0;
    int nz;
    logic [29:0] tbl [9] = '{{12'h150, 12'h150, 5'h01, 1'h1}, {12'h351, 12'h100, 5'h01, 1'h1},
        {12'hf51, 12'hf51, 5'h03, 1'h1}, {12'h152, 12'h152, 5'h07, 1'h1},
        {12'h154, 12'h154, 5'h17, 1'h1}, {12'h160, 12'h1aa, 5'h17, 1'h1},
        {12'h012, 12'h1aa, 5'h17, 1'h1}, {12'h153, 12'h153, 5'h1f, 1'h0},
        {12'h1ff, 12'h1ff, 5'h00, 1'h1}};
    always #50 i_sys_clk = ~i_sys_clk;
    always @(posedge i_sys_clk) if (er === 1'b1) ne++;
    mfo_lt_model lt (.i_sys_clk(i_sys_clk), .i_nrst(i_nrst), .i_eoc_word(ew), .i_bad_crc(bad),
        .i_tx_bit(tb), .i_tx_stb(ts), .o_mf_start(ms), .o_bit_stb(st), .o_bit_kind(kd),
        .o_frame_idx(fi), .o_rx_bit(rx), .o_tx_data(td), .o_m4(m4), .o_res(rs), .o_eoc(eo),
        .o_crc_ok(ok), .o_mf_cnt(mc));
    mfo_engine #(.P_PROC_CYCLES(200)) dut (.i_sys_clk(i_sys_clk), .i_nrst(i_nrst),
        .i_mf_start(ms), .i_bit_stb(st), .i_bit_kind(kd), .i_frame_idx(fi), .i_rx_bit(rx),
        .i_tx_bit(td), .i_avs_address(adr), .i_avs_read(rd), .i_avs_write(wr),
        .i_avs_writedata(wd), .i_avs_byteenable(4'hf), .o_avs_readdata(rdat),
        .o_avs_waitrequest(wq), .o_tx_bit(tb), .o_tx_stb(ts), .o_mf_errored(er),
        .o_loop_2bd(ac[0]), .o_loop_b1(ac[1]), .o_loop_b2(ac[2]), .o_corrupt_crc(ac[3]),
        .o_notify_crc(ac[4]));
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        samples_checked++;
        if (s !== e) begin
            n_mismatch++;
            $display("ERROR %0t seen %h expected %h", $time, s, e);
        end
    endtask : chk
    task automatic end_of_test();
        $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : end_of_test
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        int n = 0;
        @(posedge i_sys_clk);
        wr <= w;
        rd <= !w;
        adr <= a;
        wd <= d;
        do begin
            @(posedge i_sys_clk);
            n++;
        end while (wq !== 1'b0 && n < 20);
        q = rdat;
        wr <= 0;
        rd <= 0;
        if (n >= 20) begin
            n_mismatch++;
            end_of_test();
        end
    endtask : bus
    task automatic wmf(input int n);
        int t = 0;
        int s = int'(mc);
        while (int'(mc) - s < n && t < 400 * n) begin
            @(posedge i_sys_clk);
            t++;
        end
        if (t >= 400 * n) begin
            n_mismatch++;
            end_of_test();
        end
    endtask : wmf
    initial begin
        repeat (8) @(posedge i_sys_clk);
        chk(wq, 1);
        chk({tb, ts, er, ac}, 32'h80);
        i_nrst <= 1;
        bus(0, 4'h0, 0);
        chk(q, 32'h1e);
        // Unmapped place: write dropped, reads zero
        bus(1, 4'h2, 32'hffff_ffff);
        bus(0, 4'h2, 0);
        chk(q, 0);
        bus(0, 4'hc, 0);
        chk(q, 0);
        wmf(3);
        chk(m4, 8'hee);
        chk(rs, 4'hf);
        $display("test reset done");
        for (int i = 0; i < 9; i++) begin
            ew <= tbl[i][29:18];
            wmf(5);
            chk(eo, {2{tbl[i][17:6]}});
            chk(ac, tbl[i][5:1]);
            chk(ok, tbl[i][0]);
            $display("test row %0d done", i);
        end
        bad <= 1;
        wmf(1);
        bad <= 0;
        nz = 0;
        repeat (4) begin
            wmf(1);
            nz += int'(!rs[3]);
        end
        chk(nz, 1);
        chk(ne, 1);
        bus(0, 4'hc, 0);
        chk(q, 1);
        bus(1, 4'hc, 0);
        bus(0, 4'hc, 0);
        chk(q, 0);
        $display("test check error done");
        bus(1, 4'h0, 32'h1f);
        wmf(2);
        chk(m4, 8'hef);
        bus(1, 4'h0, 32'h1e);
        nz = 0;
        repeat (2) begin
            wmf(1);
            nz += int'(m4[0]);
        end
        chk(nz, 2);
        wmf(3);
        chk(m4, 8'hee);
        $display("test status repeat done");
        end_of_test();
    end
endmodule : mfo_engine_tb

// *** testbench/mfo_lt_model.sv ***
// Purpose: Line side model: framer strobes, received stream, capture of sent overhead
// Assumes: Two clocks per line bit, nine bits per basic frame
// Notes: Sent check field is compared with a check code kept here
`timescale 1ns/10ps
module mfo_lt_model (
    input wire logic i_sys_clk,
    input wire logic i_nrst,
    input wire logic [11:0] i_eoc_word,
    input wire logic i_bad_crc,
    input wire logic i_tx_bit,
    input wire logic i_tx_stb,
    output logic o_mf_start,
    output logic o_bit_stb,
    output mfo_pkg::mfo_bit_kind_t o_bit_kind,
    output logic [2:0] o_frame_idx,
    output logic o_rx_bit,
    output logic o_tx_data,
    output logic [7:0] o_m4,
    output logic [3:0] o_res,
    output logic [23:0] o_eoc,
    output logic o_crc_ok,
    output logic [15:0] o_mf_cnt
);
    int p, f, j, k, lf, lk;
    logic ph, b;
    logic ok = 1;
    logic [11:0] rc = 0, rl = 0, tc = 0, tl = 0;
    function automatic logic [11:0] crc_step(input logic [11:0] c, input logic d);
        return {c[10:0], 1'b0} ^ ((d ^ c[11]) ? 12'h80f : 12'h000);
    endfunction : crc_step
    always @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            p = 0;
            ph = 0;
            o_bit_stb <= 0;
            o_mf_start <= 0;
            o_mf_cnt <= 16'h0;
        end else begin
            // Capture first, so the last bit of a multiframe lands before the latch
            if (i_tx_stb) begin
                if (lk == 0 || lk == 5) tc = crc_step(tc, i_tx_bit);
                if (lk == 5) o_m4[lf] <= i_tx_bit;
                if (lk > 1 && lk < 5) o_eoc[25 - lf * 3 - lk] <= i_tx_bit;
                if (lk > 5 && lf < 2) o_res[lf * 2 + lk - 6] <= i_tx_bit;
                if (lk > 5 && lf > 1 && i_tx_bit !== tl[21 - 2 * lf - lk]) ok = 0;
            end
            ph = !ph;
            if (!ph) begin
                o_bit_stb <= 0;
                o_mf_start <= 0;
                p = (p + 1) % 72;
            end else begin
                f = p / 9;
                j = p % 9;
                k = (j == 0) ? 1 : (j < 3) ? 0 : j - 1;
                if (p == 0) begin
                    rl = rc;
                    rc = 0;
                    tl = tc;
                    tc = 0;
                    o_crc_ok <= ok;
                    ok = 1;
                    o_mf_cnt <= o_mf_cnt + 16'h1;
                end
                case (k)
                    0: b = p[1] ^ p[4];
                    2, 3, 4: b = i_eoc_word[13 - (f % 4) * 3 - k];
                    6, 7: b = (f < 2) ? 1'b1 : rl[21 - 2 * f - k] ^ (i_bad_crc && f == 7);
                    default: b = (k != 1);
                endcase
                if (k == 0 || k == 5) rc = crc_step(rc, b);
                o_rx_bit <= b;
                o_tx_data <= p[0] ^ p[3];
                o_bit_kind <= mfo_pkg::mfo_bit_kind_t'(k[2:0]);
                o_frame_idx <= f[2:0];
                o_bit_stb <= 1;
                o_mf_start <= (p == 0);
                lf = f;
                lk = k;
            end
        end
    end
endmodule : mfo_lt_model
